/* pkg/pdpr_regs.svh */
/*
 * register offsets, field positions and reset values of the diagnostic
 * and power register slice.
 * assumes: included by bare name from the top design file, the checker and the bench.
 */
`ifndef PDPR_REGS_SVH
`define PDPR_REGS_SVH

// ------------------------------------------------------------------
// offsets
// ------------------------------------------------------------------
`define PDPR_ADDR_W 16
`define PDPR_DATA_W 16
`define PDPR_OFS_LOC_PAIR_A 16'h0180
`define PDPR_OFS_LOC_PAIR_B 16'h0181
`define PDPR_OFS_PEAK_POL 16'h018a
`define PDPR_OFS_SELF_MGD 16'h018b
`define PDPR_OFS_PWR_CTL 16'h018c
`define PDPR_OFS_NOISE 16'h0197

// ------------------------------------------------------------------
// fields
// ------------------------------------------------------------------
`define PDPR_POL_LSB 11
`define PDPR_POL_MSB 14
`define PDPR_SMC_AUTO_BIT 6
`define PDPR_SMC_RSV_HI_LSB 7
`define PDPR_SMC_RSV_HI_MSB 15
`define PDPR_SMC_RSV_LO_LSB 2
`define PDPR_SMC_RSV_LO_MSB 5
`define PDPR_SMC_SLEEP_EN_BIT 1
`define PDPR_SMC_LPS_EN_BIT 0
`define PDPR_PSC_SLEEP_REQ_BIT 1
`define PDPR_PSC_NORMAL_BIT 0
`define PDPR_PSC_RSV_LSB 2
`define PDPR_PSC_RSV_MSB 15
`define PDPR_NOISE_MSB 8
`define PDPR_NOISE_W 9

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define PDPR_RST_SMC_RSV_HI 9'h000
`define PDPR_RST_SMC_RSV_LO 4'h6
`define PDPR_RST_SLEEP_EN 1'b1
`define PDPR_RST_LPS_EN 1'b0
`define PDPR_RST_PSC_RSV 14'h0000
`define PDPR_RST_NOISE 9'h000
`define PDPR_RST_WORD 16'h0000

`endif

/* pkg/pdpr_pkg.sv */
/*
 * types shared by the register slice and its power sequencer.
 * assumes: compiled before every design file.
 */
package pdpr_pkg;
    typedef enum logic [1:0] {
        PDPR_ST_NORMAL = 2'b00,
        PDPR_ST_LPS_TX = 2'b01,
        PDPR_ST_SLEEP = 2'b10,
        PDPR_ST_STANDBY = 2'b11
    } pdpr_pwr_state_t;
endpackage

/* design/pdpr_auto_ctl.sv */
/*
 * autonomous / managed mode holder with the read-once command bit.
 * assumes: strap level is stable around reset release; hit strobes are
 * one cycle long and come from the register decode.
 */
`timescale 1ns/1ps
`default_nettype none

module pdpr_auto_ctl (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic strap_autonomous_in,
    input wire logic rd_hit_in,
    input wire logic wr_hit_in,
    input wire logic wr_bit_in,
    output logic autonomous_out,
    output logic cmd_read_out
);
    import pdpr_pkg::*;

    logic strap_taken_q;
    logic auto_q;
    logic consumed_q;

    // ------------------------------------------------------------------
    // strap capture and mode
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_taken_q <= 1'b0;
        end else begin
            strap_taken_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            auto_q <= 1'b0;
        end else if (!strap_taken_q) begin
            auto_q <= strap_autonomous_in;
        end else if (wr_hit_in && wr_bit_in) begin
            auto_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            consumed_q <= 1'b0;
        end else if (strap_taken_q && (rd_hit_in || wr_hit_in)) begin
            consumed_q <= 1'b1;
        end
    end

    assign autonomous_out = auto_q;
    assign cmd_read_out = auto_q & strap_taken_q & ~consumed_q;
endmodule

`default_nettype wire

/* design/pdpr_pwr_seq.sv */
/*
 * power state sequencer: normal, lps transmission, sleep, standby.
 * assumes: negotiation-done and wake are one-cycle or level events from
 * the link logic, synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module pdpr_pwr_seq (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic sleep_req_in,
    input wire logic sleep_en_in,
    input wire logic normal_cmd_in,
    input wire logic lps_done_in,
    input wire logic wake_in,
    output pdpr_pkg::pdpr_pwr_state_t state_out,
    output logic standby_exit_out
);
    import pdpr_pkg::*;

    pdpr_pwr_state_t state_q;
    pdpr_pwr_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (normal_cmd_in) begin
            state_d = PDPR_ST_NORMAL;
        end else begin
            unique case (state_q)
                PDPR_ST_NORMAL: begin
                    if (sleep_req_in) begin
                        state_d = PDPR_ST_LPS_TX;
                    end
                end
                PDPR_ST_LPS_TX: begin
                    if (lps_done_in) begin
                        state_d = sleep_en_in ? PDPR_ST_SLEEP : PDPR_ST_STANDBY;
                    end else if (!sleep_req_in) begin
                        state_d = PDPR_ST_NORMAL;
                    end
                end
                PDPR_ST_SLEEP: begin
                    if (wake_in) begin
                        state_d = PDPR_ST_NORMAL;
                    end
                end
                PDPR_ST_STANDBY: begin
                    if (wake_in) begin
                        state_d = PDPR_ST_NORMAL;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= PDPR_ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    assign state_out = state_q;
    assign standby_exit_out = (state_q == PDPR_ST_STANDBY) && (state_d == PDPR_ST_NORMAL);
endmodule

`default_nettype wire

/* design/pdpr_top.sv */
/*
 * diagnostic and power register slice of a single-pair ethernet phy:
 * echo peak polarity, self-managed control, power state control and
 * noise ratio readout, on a plain strobe register port.
 * assumes: reflectometry results, noise ratio and link events arrive
 * synchronous to clk_in; read data is taken one cycle after the strobe.
 */
// Our own choice: strobed register access.
// Behaviour
// - Bits 14 down to 11 of the polarity register give peaks four to one, 1 negative, 0 positive.
// - A peak type bit counts only when its location byte in pair a or pair b is nonzero.
// - Bit 6 of self-managed control selects autonomous when 1, and starts from the reset strap.
// - The autonomous command bit reads zero after its first read or write.
// - Managed operation is entered only by the reset strap, never by a write.
// - After lps negotiation the device goes to sleep when sleep enable is set, else to standby.
// - Lps code-groups are sent only while lps transmission enable is set.
// - Writing 1 to the sleep request bit makes the device send lps code-groups when lps transmission enable is set.
// - Writing 1 to the normal command bit forces the normal power state.
// - The normal command bit clears itself only on the standby to normal move.
// - The noise field, bits 8 to 0, holds ten times the ratio in dB; bits 15 to 9 read zero.
// - A location byte gives distance 1.5 times (value minus four) meters, zero meaning no peak.
`timescale 1ns/1ps
`default_nettype none
`include "pdpr_regs.svh"

module pdpr_top #(
    parameter int ADDR_W = `PDPR_ADDR_W,
    parameter int DATA_W = `PDPR_DATA_W
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    input wire logic strap_autonomous_in,
    input wire logic [3:0] peak_type_in,
    input wire logic [15:0] loc_pair_a_in,
    input wire logic [15:0] loc_pair_b_in,
    input wire logic [`PDPR_NOISE_MSB:0] noise_ratio_in,
    input wire logic lps_done_in,
    input wire logic wake_in,
    output logic autonomous_out,
    output logic send_lps_out,
    output pdpr_pkg::pdpr_pwr_state_t power_state_out
);
    import pdpr_pkg::*;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic hit_smc;
    logic hit_psc;
    logic wr_smc;
    logic wr_psc;
    logic rd_smc;

    assign hit_smc = (reg_addr_in == ADDR_W'(`PDPR_OFS_SELF_MGD));
    assign hit_psc = (reg_addr_in == ADDR_W'(`PDPR_OFS_PWR_CTL));
    assign wr_smc = reg_wr_in && hit_smc;
    assign wr_psc = reg_wr_in && hit_psc;
    assign rd_smc = reg_rd_in && hit_smc;

    // ------------------------------------------------------------------
    // result capture
    // ------------------------------------------------------------------
    logic [3:0] peak_type_q;
    logic [15:0] loc_a_q;
    logic [15:0] loc_b_q;
    logic [`PDPR_NOISE_MSB:0] noise_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            peak_type_q <= 4'h0;
            loc_a_q <= `PDPR_RST_WORD;
            loc_b_q <= `PDPR_RST_WORD;
        end else begin
            peak_type_q <= peak_type_in;
            loc_a_q <= loc_pair_a_in;
            loc_b_q <= loc_pair_b_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            noise_q <= `PDPR_RST_NOISE;
        end else begin
            noise_q <= noise_ratio_in;
        end
    end

    logic [3:0] peak_found;
    assign peak_found[0] = |loc_a_q[7:0];
    assign peak_found[1] = |loc_a_q[15:8];
    assign peak_found[2] = |loc_b_q[7:0];
    assign peak_found[3] = |loc_b_q[15:8];

    // ------------------------------------------------------------------
    // self-managed control
    // ------------------------------------------------------------------
    logic [8:0] smc_rsv_hi_q;
    logic [3:0] smc_rsv_lo_q;
    logic sleep_en_q;
    logic lps_en_q;
    logic auto_mode;
    logic auto_cmd_rd;

    pdpr_auto_ctl u_auto (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .strap_autonomous_in(strap_autonomous_in),
        .rd_hit_in(rd_smc),
        .wr_hit_in(wr_smc),
        .wr_bit_in(reg_wdata_in[`PDPR_SMC_AUTO_BIT]),
        .autonomous_out(auto_mode),
        .cmd_read_out(auto_cmd_rd)
    );

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            smc_rsv_hi_q <= `PDPR_RST_SMC_RSV_HI;
            smc_rsv_lo_q <= `PDPR_RST_SMC_RSV_LO;
            sleep_en_q <= `PDPR_RST_SLEEP_EN;
            lps_en_q <= `PDPR_RST_LPS_EN;
        end else if (wr_smc) begin
            smc_rsv_hi_q <= reg_wdata_in[`PDPR_SMC_RSV_HI_MSB:`PDPR_SMC_RSV_HI_LSB];
            smc_rsv_lo_q <= reg_wdata_in[`PDPR_SMC_RSV_LO_MSB:`PDPR_SMC_RSV_LO_LSB];
            sleep_en_q <= reg_wdata_in[`PDPR_SMC_SLEEP_EN_BIT];
            lps_en_q <= reg_wdata_in[`PDPR_SMC_LPS_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // power state control
    // ------------------------------------------------------------------
    logic [13:0] psc_rsv_q;
    logic sleep_req_q;
    logic normal_cmd_q;
    logic standby_exit;
    pdpr_pwr_state_t pwr_state;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            psc_rsv_q <= `PDPR_RST_PSC_RSV;
            sleep_req_q <= 1'b0;
        end else if (wr_psc) begin
            psc_rsv_q <= reg_wdata_in[`PDPR_PSC_RSV_MSB:`PDPR_PSC_RSV_LSB];
            sleep_req_q <= reg_wdata_in[`PDPR_PSC_SLEEP_REQ_BIT];
        end
    end

    // self clear on standby exit, a write of 1 wins
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            normal_cmd_q <= 1'b0;
        end else if (wr_psc) begin
            normal_cmd_q <= reg_wdata_in[`PDPR_PSC_NORMAL_BIT];
        end else if (standby_exit) begin
            normal_cmd_q <= 1'b0;
        end
    end

    pdpr_pwr_seq u_seq (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .sleep_req_in(sleep_req_q),
        .sleep_en_in(sleep_en_q),
        .normal_cmd_in(normal_cmd_q),
        .lps_done_in(lps_done_in),
        .wake_in(wake_in),
        .state_out(pwr_state),
        .standby_exit_out(standby_exit)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic send_lps_q;
    logic auto_out_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            send_lps_q <= 1'b0;
        end else begin
            send_lps_q <= lps_en_q && sleep_req_q && (pwr_state == PDPR_ST_LPS_TX);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            auto_out_q <= 1'b0;
        end else begin
            auto_out_q <= auto_mode;
        end
    end

    assign send_lps_out = send_lps_q;
    assign autonomous_out = auto_out_q;
    assign power_state_out = pwr_state;

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;

    always_comb begin
        rdata_d = DATA_W'(`PDPR_RST_WORD);
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_W'(`PDPR_OFS_LOC_PAIR_A): begin
                    rdata_d = DATA_W'(loc_a_q);
                end
                ADDR_W'(`PDPR_OFS_LOC_PAIR_B): begin
                    rdata_d = DATA_W'(loc_b_q);
                end
                ADDR_W'(`PDPR_OFS_PEAK_POL): begin
                    rdata_d[`PDPR_POL_MSB:`PDPR_POL_LSB] = peak_type_q & peak_found;
                end
                ADDR_W'(`PDPR_OFS_SELF_MGD): begin
                    rdata_d[`PDPR_SMC_RSV_HI_MSB:`PDPR_SMC_RSV_HI_LSB] = smc_rsv_hi_q;
                    rdata_d[`PDPR_SMC_AUTO_BIT] = auto_cmd_rd;
                    rdata_d[`PDPR_SMC_RSV_LO_MSB:`PDPR_SMC_RSV_LO_LSB] = smc_rsv_lo_q;
                    rdata_d[`PDPR_SMC_SLEEP_EN_BIT] = sleep_en_q;
                    rdata_d[`PDPR_SMC_LPS_EN_BIT] = lps_en_q;
                end
                ADDR_W'(`PDPR_OFS_PWR_CTL): begin
                    rdata_d[`PDPR_PSC_RSV_MSB:`PDPR_PSC_RSV_LSB] = psc_rsv_q;
                    rdata_d[`PDPR_PSC_SLEEP_REQ_BIT] = sleep_req_q;
                    rdata_d[`PDPR_PSC_NORMAL_BIT] = normal_cmd_q;
                end
                ADDR_W'(`PDPR_OFS_NOISE): begin
                    rdata_d[`PDPR_NOISE_MSB:0] = noise_q;
                end
                default: begin
                    rdata_d = DATA_W'(`PDPR_RST_WORD);
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= DATA_W'(`PDPR_RST_WORD);
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;
endmodule

`default_nettype wire

/* dv/pdpr_top_chk.sv */
/*
 * assertion checker for the diagnostic and power register slice.
 * assumes: bound to pdpr_top from the bench top file, sees its ports only.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdpr_regs.svh"

module pdpr_top_chk #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic lps_done_in,
    input wire logic wake_in,
    input wire logic autonomous_out,
    input wire logic send_lps_out,
    input wire pdpr_pkg::pdpr_pwr_state_t power_state_out
);
    import pdpr_pkg::*;

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_rdata_only_read: assert property (reg_rdata_out != '0 |-> $past(reg_rd_in))
        else $error("read data outside the answer cycle");
    a_pol_rsv_zero: assert property (
        $past(reg_rd_in && reg_addr_in == `PDPR_OFS_PEAK_POL)
        |-> reg_rdata_out[15] == 1'b0 && reg_rdata_out[10:0] == 11'h000)
        else $error("polarity reserved bits not zero");
    a_noise_rsv_zero: assert property (
        $past(reg_rd_in && reg_addr_in == `PDPR_OFS_NOISE)
        |-> reg_rdata_out[15:9] == 7'h00)
        else $error("noise reserved bits not zero");

    // ------------------------------------------------------------------
    // mode and power state
    // ------------------------------------------------------------------
    a_managed_no_write: assert property (!$fell(autonomous_out))
        else $error("left autonomous mode without reset");
    a_send_needs_lps: assert property (
        send_lps_out |-> $past(power_state_out) == PDPR_ST_LPS_TX)
        else $error("lps sent outside lps state");
    a_lps_entry: assert property (
        power_state_out == PDPR_ST_LPS_TX && $past(power_state_out) != PDPR_ST_LPS_TX
        |-> $past(power_state_out) == PDPR_ST_NORMAL)
        else $error("lps state entered from wrong state");
    a_sleep_entry: assert property (
        power_state_out == PDPR_ST_SLEEP && $past(power_state_out) != PDPR_ST_SLEEP
        |-> $past(power_state_out) == PDPR_ST_LPS_TX && $past(lps_done_in))
        else $error("sleep entered without negotiation");
    a_standby_entry: assert property (
        power_state_out == PDPR_ST_STANDBY && $past(power_state_out) != PDPR_ST_STANDBY
        |-> $past(power_state_out) == PDPR_ST_LPS_TX && $past(lps_done_in))
        else $error("standby entered without negotiation");
    a_wake_normal: assert property (
        (power_state_out == PDPR_ST_SLEEP || power_state_out == PDPR_ST_STANDBY) && wake_in
        |=> power_state_out == PDPR_ST_NORMAL)
        else $error("wake did not return to normal");
endmodule

`default_nettype wire

/* dv/test_phy_diag_power_regs.sv */
/*
 * self-checking bench for the diagnostic and power register slice.
 * assumes: package, header and checker compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdpr_regs.svh"

module test_phy_diag_power_regs;
    import pdpr_pkg::*;
    typedef struct {
        logic [3:0] pt;
        logic [15:0] la;
        logic [15:0] lb;
        logic [8:0] nr;
        logic [15:0] pol;
        logic [15:0] noise_ratio_readout;
    } pdpr_row_t;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic strap_autonomous_in = 1'b1;
    logic [3:0] peak_type_in = 4'h0;
    logic [15:0] loc_pair_a_in = 16'h0000;
    logic [15:0] loc_pair_b_in = 16'h0000;
    logic [8:0] noise_ratio_in = 9'h000;
    logic lps_done_in = 1'b0;
    logic wake_in = 1'b0;
    logic [15:0] reg_rdata_out;
    logic autonomous_out;
    logic send_lps_out;
    pdpr_pwr_state_t power_state_out;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    // type bit shows only where its location byte is nonzero
    pdpr_row_t rows [4] = '{
        '{4'hf, 16'h0101, 16'h0101, 9'h1ff, 16'h7800, 16'h01ff},
        '{4'hf, 16'h0100, 16'h0001, 9'h000, 16'h3000, 16'h0000},
        '{4'h5, 16'hffff, 16'hffff, 9'h0fa, 16'h2800, 16'h00fa},
        '{4'ha, 16'h0000, 16'hff00, 9'h155, 16'h4000, 16'h0155}};

    pdpr_top dut (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .strap_autonomous_in(strap_autonomous_in),
        .peak_type_in(peak_type_in),
        .loc_pair_a_in(loc_pair_a_in),
        .loc_pair_b_in(loc_pair_b_in),
        .noise_ratio_in(noise_ratio_in),
        .lps_done_in(lps_done_in),
        .wake_in(wake_in),
        .autonomous_out(autonomous_out),
        .send_lps_out(send_lps_out),
        .power_state_out(power_state_out)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    always #2 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask

    task automatic done_pulse();
        @(posedge clk_in);
        lps_done_in <= 1'b1;
        @(posedge clk_in);
        lps_done_in <= 1'b0;
        #1;
    endtask

    task automatic wake_pulse();
        @(posedge clk_in);
        wake_in <= 1'b1;
        @(posedge clk_in);
        wake_in <= 1'b0;
        #1;
    endtask

    // strap is held across release so the capture edge sees it
    task automatic do_reset(input logic s);
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        strap_autonomous_in <= s;
        settle(7);
        chk(reg_rdata_out, 16'h0000);
        chk(16'(power_state_out), 16'(PDPR_ST_NORMAL));
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        settle(2);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        chk(16'(autonomous_out), 16'h0001);
        rd(`PDPR_OFS_SELF_MGD, 16'h005a);
        rd(`PDPR_OFS_SELF_MGD, 16'h001a);
        rd(`PDPR_OFS_PWR_CTL, 16'h0000);
        rd(16'h0199, 16'h0000);
        foreach (rows[i]) begin
            @(posedge clk_in);
            peak_type_in <= rows[i].pt;
            loc_pair_a_in <= rows[i].la;
            loc_pair_b_in <= rows[i].lb;
            noise_ratio_in <= rows[i].nr;
            wr(`PDPR_OFS_PEAK_POL, 16'hffff);
            wr(`PDPR_OFS_NOISE, 16'hffff);
            rd(`PDPR_OFS_PEAK_POL, rows[i].pol);
            rd(`PDPR_OFS_NOISE, rows[i].noise_ratio_readout);
            rd(`PDPR_OFS_LOC_PAIR_A, rows[i].la);
            rd(`PDPR_OFS_LOC_PAIR_B, rows[i].lb);
        end
        wr(`PDPR_OFS_SELF_MGD, 16'h0000);
        rd(`PDPR_OFS_SELF_MGD, 16'h0000);
        chk(16'(autonomous_out), 16'h0001);
        wr(`PDPR_OFS_PWR_CTL, 16'h0002);
        settle(3);
        chk(16'(power_state_out), 16'(PDPR_ST_LPS_TX));
        chk(16'(send_lps_out), 16'h0000);
        wr(`PDPR_OFS_SELF_MGD, 16'h0003);
        settle(2);
        chk(16'(send_lps_out), 16'h0001);
        wr(`PDPR_OFS_PWR_CTL, 16'h0003);
        settle(2);
        chk(16'(power_state_out), 16'(PDPR_ST_NORMAL));
        rd(`PDPR_OFS_PWR_CTL, 16'h0003);
        wr(`PDPR_OFS_PWR_CTL, 16'h0002);
        settle(3);
        done_pulse();
        chk(16'(power_state_out), 16'(PDPR_ST_SLEEP));
        wake_pulse();
        chk(16'(power_state_out), 16'(PDPR_ST_NORMAL));
        wr(`PDPR_OFS_SELF_MGD, 16'h0001);
        done_pulse();
        chk(16'(power_state_out), 16'(PDPR_ST_STANDBY));
        wr(`PDPR_OFS_PWR_CTL, 16'h0001);
        settle(2);
        chk(16'(power_state_out), 16'(PDPR_ST_NORMAL));
        rd(`PDPR_OFS_PWR_CTL, 16'h0000);
        wr(`PDPR_OFS_PWR_CTL, 16'h0002);
        settle(3);
        chk(16'(power_state_out), 16'(PDPR_ST_LPS_TX));
        wr(`PDPR_OFS_PWR_CTL, 16'h0000);
        settle(2);
        chk(16'(power_state_out), 16'(PDPR_ST_NORMAL));
        do_reset(1'b0);
        chk(16'(autonomous_out), 16'h0000);
        rd(`PDPR_OFS_SELF_MGD, 16'h001a);
        wr(`PDPR_OFS_SELF_MGD, 16'h0042);
        settle(2);
        chk(16'(autonomous_out), 16'h0001);
        rd(`PDPR_OFS_SELF_MGD, 16'h0002);
        final_report();
    end
endmodule

bind pdpr_top pdpr_top_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .lps_done_in(lps_done_in),
    .wake_in(wake_in),
    .autonomous_out(autonomous_out),
    .send_lps_out(send_lps_out),
    .power_state_out(power_state_out)
);

`default_nettype wire
